/* dv/fcds_core_monitor.sv */
// Port checker for the complement / decrement-skip core.
// Bound to the core top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fcds_core_monitor import fcds_pkg::*; (
  input wire logic               CLK_SYS_I,
  input wire logic               RSTN_I,
  input wire logic [INSTR_W-1:0] INSTR_I,
  input wire logic [DATA_W-1:0]  FILE_RDATA_I,
  input wire logic [FADDR_W-1:0] FILE_ADDR_O,
  input wire logic               FILE_RD_O,
  input wire logic               FILE_WE_O,
  input wire logic [DATA_W-1:0]  FILE_WDATA_O,
  input wire logic [DATA_W-1:0]  W_O,
  input wire logic               Z_O,
  input wire logic               SKIP_O,
  input wire logic               SQUASH_O,
  input wire logic [1:0]         PHASE_O
);
  // Attempts at the release edge already see reset high; hold them off a clock.
  logic run_ok;
  always_ff @(posedge CLK_SYS_I) begin
    run_ok <= RSTN_I;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I || !run_ok);
  wire logic tk = PHASE_O == 2'h0 && !SQUASH_O;
  wire logic cm = tk && INSTR_I[13:8] == OPC_COMPLEMENT;
  wire logic dk = tk && INSTR_I[13:8] == OPC_DEC_SKIP;
  wire logic [FADDR_W-1:0] fa = INSTR_I[6:0];
  property p_ph; PHASE_O == 2'h0 |=> PHASE_O == 2'h1 ##1 PHASE_O == 2'h2; endproperty
  a_ph: assert property (p_ph) else $error("phase order");
  property p_cm;
    cm |=> FILE_RD_O ##3 (FILE_WE_O ? FILE_WDATA_O : W_O) == ~$past(FILE_RDATA_I, 3);
  endproperty
  a_cm: assert property (p_cm) else $error("complement result");
  property p_z; cm |=> ##3 Z_O == ($past(FILE_RDATA_I, 3) == 8'hff); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_dk;
    dk |=> FILE_RD_O ##3 (FILE_WE_O ? FILE_WDATA_O : W_O) == $past(FILE_RDATA_I, 3) - 8'h01
      && Z_O == $past(Z_O, 3);
  endproperty
  a_dk: assert property (p_dk) else $error("decrement result");
  property p_sk; dk |=> ##3 SKIP_O == ($past(FILE_RDATA_I, 3) == 8'h01); endproperty
  a_sk: assert property (p_sk) else $error("skip");
  property p_sq; SKIP_O |-> SQUASH_O ##1 (SQUASH_O && !FILE_RD_O)[*3] ##1 !SQUASH_O; endproperty
  a_sq: assert property (p_sq) else $error("squash");
  property p_fa; cm || dk |=> FILE_ADDR_O == $past(fa); endproperty
  a_fa: assert property (p_fa) else $error("file address");
  c_sk: cover property (SKIP_O);
  c_we: cover property (FILE_WE_O);
  c_cw: cover property (cm && !INSTR_I[7]);
endmodule // fcds_core_monitor
bind fcds_core fcds_core_monitor mon (.CLK_SYS_I, .RSTN_I, .INSTR_I, .FILE_RDATA_I,
  .FILE_ADDR_O, .FILE_RD_O, .FILE_WE_O, .FILE_WDATA_O, .W_O, .Z_O, .SKIP_O, .SQUASH_O,
  .PHASE_O);
`default_nettype wire

/* dv/fcds_core_tb.sv */
// Bench: random back-to-back instructions against the memory model.
// Keeps its own copy of the file memory to predict results.
`timescale 1ns/1ps
`default_nettype none
module fcds_core_tb import fcds_pkg::*;;
  logic clk = 0, rstn = 0;
  logic [INSTR_W-1:0] ins = '0;
  wire logic [DATA_W-1:0] rdat, wdat, w;
  wire logic [FADDR_W-1:0] fa;
  wire logic rd, we, z, sk;
  wire logic [1:0] ph;
  logic [18:0] q[$];
  logic [DATA_W-1:0] sh[128], ew;
  logic ez, pend, armed = 0;
  logic [OPC_W-1:0] ops[4] = '{OPC_COMPLEMENT, OPC_DEC_SKIP, 6'h00, 6'h3f};
  int errors = 0, tests_run = 0, seed = 196, cyc = 0;
  fcds_core dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .INSTR_I(ins), .FILE_RDATA_I(rdat),
    .FILE_ADDR_O(fa), .FILE_RD_O(rd), .FILE_WE_O(we), .FILE_WDATA_O(wdat), .W_O(w),
    .Z_O(z), .SKIP_O(sk), .SQUASH_O(), .PHASE_O(ph));
  fcds_mem_model mem (.clk_i(clk), .rd_i(rd), .we_i(we), .addr_i(fa), .wdata_i(wdat),
    .rdata_o(rdat));
  initial forever #12.5 clk = ~clk;
  task automatic close_out;
    // A note that no result ever matched is a mismatch too.
    if (q.size() != 0) errors++;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [18:0] e, g);
    tests_run++;
    if (e !== g) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic issue(input logic [INSTR_W-1:0] i);
    logic [7:0] v;
    do @(negedge clk); while (ph !== 2'h3);
    @(posedge clk);
    ins <= i;
    if (pend) pend = 0;
    else if (i[13:8] == OPC_COMPLEMENT || i[13:8] == OPC_DEC_SKIP) begin
      v = i[13:8] == OPC_COMPLEMENT ? ~sh[i[6:0]] : sh[i[6:0]] - 8'h01;
      if (i[13:8] == OPC_COMPLEMENT) ez = v == 8'h00;
      if (i[7]) sh[i[6:0]] = v;
      else ew = v;
      pend = i[13:8] == OPC_DEC_SKIP && v == 8'h00;
      q.push_back({i[7], i[7] ? v : 8'h00, ew, ez, pend});
    end
  endtask
  always @(negedge clk) begin
    if (ph === 2'h1 && q.size() > 0) armed = 1;
    if (ph === 2'h0 && armed) begin
      armed = 0;
      chk("result", q.pop_front(), {we, we ? wdat : 8'h00, w, z, sk});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    ew = W_RESET;
    ez = Z_RESET;
    pend = 0;
    for (int a = 0; a < 128; a++) begin
      sh[a] = a % 3 == 0 ? 8'h01 : a % 3 == 1 ? 8'hff : 8'($random(seed));
      mem.m[a] = sh[a];
    end
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (300) issue({ops[{$random(seed)} % 4], 8'($random(seed))});
    repeat (2) issue('0);
    close_out();
  end
endmodule // fcds_core_tb
`default_nettype wire

/* dv/fcds_mem_model.sv */
// File memory partner.
// Preloaded by the bench; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module fcds_mem_model import fcds_pkg::*; (
  input  wire logic               clk_i,
  input  wire logic               rd_i,
  input  wire logic               we_i,
  input  wire logic [FADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0]  wdata_i,
  output logic      [DATA_W-1:0]  rdata_o
);
  logic [DATA_W-1:0] m [128];
  // Junk outside the read phase exposes a late sample
  assign rdata_o = rd_i ? m[addr_i] : ~m[addr_i];
  always @(posedge clk_i) if (we_i) m[addr_i] <= wdata_i;
endmodule // fcds_mem_model
`default_nettype wire

/* verilog/fcds_alu.sv */
// Result unit: complement or decrement of a file operand, with zero detect.
// Assumes load is one cycle in the process phase.
`timescale 1ns/1ps
`default_nettype none
module fcds_alu
  import fcds_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  fcds_alu_if.alu     alu_bus
);
  logic [DATA_W-1:0] next_result;

  always_comb begin
    unique case (alu_bus.op)
      OP_COMPLEMENT: next_result = ~alu_bus.operand;
      OP_DEC_SKIP:   next_result = alu_bus.operand - {{(DATA_W-1){1'b0}}, 1'b1};
      default:       next_result = alu_bus.operand;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      alu_bus.result <= W_RESET;
      alu_bus.zero   <= Z_RESET;
    end else if (alu_bus.load) begin
      alu_bus.result <= next_result;
      alu_bus.zero   <= (next_result == '0);
    end
  end
endmodule // fcds_alu
`default_nettype wire

/* verilog/fcds_alu_if.sv */
// Carrier between the core sequencer and its result unit.
// Both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface fcds_alu_if import fcds_pkg::*; ();
  logic [DATA_W-1:0] operand;
  fcds_op_type       op;
  logic              load;
  logic [DATA_W-1:0] result;
  logic              zero;

  modport core (output operand, output op, output load, input result, input zero);
  modport alu  (input operand, input op, input load, output result, output zero);
endinterface
`default_nettype wire

/* verilog/fcds_core.sv */
// Core slice executing complement-file and decrement-skip-if-zero.
// Assumes the fetch side presents the instruction during the decode phase and
// the data memory returns read data combinationally from FILE_ADDR_O.
// The fetch side drops its next word when SKIP_O pulses; this slice refuses it too.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Complement inverts every file bit; dest bit 0 writes W, 1 writes file.
// - Each instruction cycle runs decode, read, process, write phases in order.
// - Decrement-skip subtracts one; dest bit selects W or file as target.
// - Zero decrement result squashes next fetched instruction into a no-operation.
// - File address is seven bits, 0 to 127; destination select is one bit.
// - Complement sets zero flag when result is zero, clears it otherwise.
module fcds_core
  import fcds_pkg::*;
(
  input  wire logic               CLK_SYS_I,
  input  wire logic               RSTN_I,
  input  wire logic [INSTR_W-1:0] INSTR_I,
  input  wire logic [DATA_W-1:0]  FILE_RDATA_I,
  output logic [FADDR_W-1:0]      FILE_ADDR_O,
  output logic                    FILE_RD_O,
  output logic                    FILE_WE_O,
  output logic [DATA_W-1:0]       FILE_WDATA_O,
  output logic [DATA_W-1:0]       W_O,
  output logic                    Z_O,
  output logic                    SKIP_O,
  output logic                    SQUASH_O,
  output logic [1:0]              PHASE_O
);
  fcds_phase_type    phase;
  fcds_phase_type    next_phase;
  fcds_op_type       op;
  fcds_op_type       next_op;
  logic              dest_file;
  logic              squash;
  logic [DATA_W-1:0] operand;
  logic [OPC_W-1:0]  opcode;
  logic              next_file_rd;
  logic              commit;
  logic              skip_hit;

  fcds_alu_if alu_bus ();

  // Result unit registers its zero detect, so skip and flag see a settled value.
  fcds_alu u_alu (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .alu_bus (alu_bus)
  );

  // Four phases in fixed order; every code of the phase type is used.
  always_comb begin
    unique case (phase)
      PH_DECODE:  next_phase = PH_READ;
      PH_READ:    next_phase = PH_PROCESS;
      PH_PROCESS: next_phase = PH_WRITE;
      PH_WRITE:   next_phase = PH_DECODE;
    endcase
  end

  // Only the two opcodes of this slice are recognised; anything else idles,
  // so the rest of the instruction set can sit beside this slice unharmed.
  assign opcode = INSTR_I[OPC_LSB +: OPC_W];

  always_comb begin
    if (opcode == OPC_COMPLEMENT) begin
      next_op = OP_COMPLEMENT;
    end else if (opcode == OPC_DEC_SKIP) begin
      next_op = OP_DEC_SKIP;
    end else begin
      next_op = OP_NONE;
    end
  end

  // Phase sequencer: free running, one phase per clock. An instruction cycle
  // is therefore four clocks and the fetch side must present a new word in
  // every decode phase; there is no stall.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      phase <= PH_DECODE;
    end else begin
      phase <= next_phase;
    end
  end

  // Phase is mirrored on the pins so fetch can line its word up with decode.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      PHASE_O <= 2'h0;
    end else begin
      PHASE_O <= next_phase;
    end
  end

  // Decode: a squashed cycle decodes as nothing so the fetched word never runs.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      op <= OP_NONE;
    end else if (phase == PH_DECODE) begin
      op <= squash ? OP_NONE : next_op;
    end
  end

  // Destination select is a single bit; 1 sends the result back to the file.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      dest_file <= 1'b0;
    end else if (phase == PH_DECODE) begin
      dest_file <= INSTR_I[DEST_BIT];
    end
  end

  // The address stands for the whole cycle and into the next decode phase,
  // so the late write strobe still lands on the register that was read.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      FILE_ADDR_O <= ADDR_RESET;
    end else if (phase == PH_DECODE) begin
      FILE_ADDR_O <= INSTR_I[FADDR_W-1:0];
    end
  end

  // Read strobe covers the read phase only, and never for an idle or squashed
  // word, so the file sees no access that nothing asked for.
  assign next_file_rd = (phase == PH_DECODE) && !squash && (next_op != OP_NONE);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      FILE_RD_O <= 1'b0;
    end else begin
      FILE_RD_O <= next_file_rd;
    end
  end

  // Operand is captured at the end of the read phase while the strobe stands;
  // file data outside that phase is not to be trusted.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      operand <= W_RESET;
    end else if (phase == PH_READ) begin
      operand <= FILE_RDATA_I;
    end
  end

  // The result unit loads once per cycle, in the process phase; the write
  // phase then only routes its registered result.
  assign alu_bus.operand = operand;
  assign alu_bus.op      = op;
  assign alu_bus.load    = (phase == PH_PROCESS);

  // Commit only a recognised, unsquashed instruction.
  assign commit   = (phase == PH_WRITE) && (op != OP_NONE);
  assign skip_hit = (op == OP_DEC_SKIP) && alu_bus.zero;

  // Working accumulator keeps its value when the result goes to the file.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      W_O <= W_RESET;
    end else if (commit && !dest_file) begin
      W_O <= alu_bus.result;
    end
  end

  // The write strobe lands in the next decode phase, before that instruction's
  // read, so a back-to-back access to the same register sees the new value.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      FILE_WE_O <= 1'b0;
    end else begin
      FILE_WE_O <= commit && dest_file;
    end
  end

  // Write data holds after the strobe; the file only takes it with the strobe.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      FILE_WDATA_O <= W_RESET;
    end else if (commit && dest_file) begin
      FILE_WDATA_O <= alu_bus.result;
    end
  end

  // Zero flag follows complement only; decrement-skip leaves it alone.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      Z_O <= Z_RESET;
    end else if (phase == PH_WRITE && op == OP_COMPLEMENT) begin
      Z_O <= alu_bus.zero;
    end
  end

  // Squash holds through the whole following cycle, making the skipping
  // instruction take two cycles; the discarded word runs as a no-operation.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      squash <= 1'b0;
    end else if (phase == PH_WRITE) begin
      squash <= skip_hit;
    end
  end

  // Fetch sees the same squash window on its own pin.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      SQUASH_O <= 1'b0;
    end else if (phase == PH_WRITE) begin
      SQUASH_O <= skip_hit;
    end
  end

  // One-cycle notice to fetch, in the decode phase of the discarded word.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      SKIP_O <= 1'b0;
    end else begin
      SKIP_O <= (phase == PH_WRITE) && skip_hit;
    end
  end
endmodule // fcds_core
`default_nettype wire

/* verilog/fcds_pkg.sv */
// Constants and types for the complement-file / decrement-skip-zero slice.
// Assumes a 14-bit instruction word and an 8-bit data memory.
package fcds_pkg;
  localparam int unsigned         INSTR_W  = 14;
  localparam int unsigned         DATA_W   = 8;
  localparam int unsigned         FADDR_W  = 7;
  localparam int unsigned         OPC_W    = 6;
  localparam int unsigned         OPC_LSB  = 8;
  localparam int unsigned         DEST_BIT = 7;
  localparam logic [OPC_W-1:0]    OPC_COMPLEMENT = 6'h09;
  localparam logic [OPC_W-1:0]    OPC_DEC_SKIP   = 6'h0b;
  localparam logic [DATA_W-1:0]   W_RESET  = 8'h00;
  localparam logic                Z_RESET  = 1'b0;
  localparam logic [FADDR_W-1:0]  ADDR_RESET = 7'h00;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_COMPLEMENT,
    OP_DEC_SKIP
  } fcds_op_type;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } fcds_phase_type;
endpackage
